// >>> dv/testbench.sv
// Self-checking bench for the read-only capability words
`timescale 1ns/100ps
`include "capstat_regs.svh"
module testbench;
  import capstat_pkg::*;
  // Short readiness budget keeps the run brief
  localparam int READY_N = 8;
  // Clock, reset and stimulus
  logic ref_clk;
  logic sys_rst;
  reg_req_s reg_req;
  logic lookup_valid;
  logic [63:0] lookup_addr;
  // One lane per legal width code, so every legal code is reported somewhere
  wire logic [4:0][31:0] rdata_v;
  wire logic [4:0] rdy_v;
  wire logic [4:0] ok_v;
  wire logic [4:0] err_v;
  // Tallies
  int bad_count;
  int samples_checked;

  // Lane k: odd lanes are multi-port and partial, bit 1 of k gives 128B
  for (genvar k = 0; k < 5; k++)
  begin : g_lane
    common_capability_status_two #(
      .PARTIAL_LINE((k % 2) == 1),
      .PORT_GROUPING(1'b1),
      .LINE_128(((k / 2) % 2) == 1),
      .WIDTH_CODE(3'(k)),
      .MULTI_PORT(((k % 2) == 1) ? 3'h3 : 3'h2),
      .READY_CYCLES(READY_N)
    ) i_dut (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .reg_req(reg_req),
      .reg_rdata(rdata_v[k]),
      .discovery_ready(rdy_v[k]),
      .lookup_valid(lookup_valid),
      .lookup_addr(lookup_addr),
      .lookup_ok(ok_v[k]),
      .lookup_err(err_v[k])
    );
  end

  // Free-running 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Expected second word; grouping survives only with multi-port bit 0
  function automatic logic [31:0] word_two(input int k, input logic rdy);
    logic [2:0] c;
    c = 3'(k);
    return {25'h0, c, c[1], c[0], c[0], rdy};
  endfunction

  // Address fits when nothing sits at or above the reported width
  function automatic logic fits(input int k, input logic [63:0] a);
    return (a >> (48 + 4 * k)) == 64'h0;
  endfunction

  // Single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Every lane's read data must be zero outside its answer cycle
  task automatic check_idle();
    for (int k = 0; k < 5; k++)
    begin
      check(rdata_v[k], 32'h0);
    end
  endtask

  // Write of all ones that leaves the strobe up; the next access
  // clears it, so a read follows the write with no idle cycle
  task automatic write_ones(input logic [7:0] a);
    @(posedge ref_clk);
    reg_req.addr <= a;
    reg_req.wdata <= 32'hffff_ffff;
    reg_req.wr <= 1'b1;
    reg_req.rd <= 1'b0;
  endtask

  // One-cycle read or write; returns just after the data edge
  task automatic reg_access(input logic [7:0] a, input logic wr,
    input logic [31:0] wd);
    @(posedge ref_clk);
    reg_req.addr <= a;
    reg_req.wdata <= wd;
    reg_req.wr <= wr;
    reg_req.rd <= !wr;
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
    reg_req.rd <= 1'b0;
    #1;
  endtask

  // Reads both words on every lane and compares them
  task automatic read_words(input logic rdy);
    reg_access(`CAP_TWO_OFFSET, 1'b0, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      check(rdata_v[k], word_two(k, rdy));
    end
    // Data stands one cycle only
    @(posedge ref_clk);
    #1;
    check_idle();
    reg_access(`CAP_ONE_OFFSET, 1'b0, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      check(rdata_v[k], (k % 2) ? 32'h3 : 32'h2);
    end
  endtask

  // One decode check on every lane, then the idle cycle after it
  task automatic lookup(input logic [63:0] a);
    @(posedge ref_clk);
    lookup_valid <= 1'b1;
    lookup_addr <= a;
    @(posedge ref_clk);
    lookup_valid <= 1'b0;
    #1;
    for (int k = 0; k < 5; k++)
    begin
      check(32'({ok_v[k], err_v[k]}), fits(k, a) ? 32'h2 : 32'h1);
    end
    @(posedge ref_clk);
    #1;
    check(32'({ok_v, err_v}), 32'h0);
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    reg_req = '0;
    lookup_valid = 1'b0;
    lookup_addr = 64'h0;
    bad_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge ref_clk);
    #1;
    check_idle();
    check(32'(rdy_v), 32'h0);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Early read sees not-ready
    reg_access(`CAP_TWO_OFFSET, 1'b0, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      check(rdata_v[k], word_two(k, 1'b0));
    end
    // Ready must rise exactly at edge READY_N + 1 after release
    repeat (READY_N - 2) @(posedge ref_clk);
    #1;
    check(32'(rdy_v), 32'h0);
    @(posedge ref_clk);
    #1;
    check(32'(rdy_v), 32'h1f);
    read_words(1'b1);
    // A write of all ones to the second word answers no read data on any lane
    reg_access(`CAP_TWO_OFFSET, 1'b1, 32'hffff_ffff);
    check_idle();
    // A write straight before a read, both ways round
    write_ones(`CAP_ONE_OFFSET);
    read_words(1'b1);
    write_ones(`CAP_TWO_OFFSET);
    reg_access(`CAP_ONE_OFFSET, 1'b0, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      check(rdata_v[k], (k % 2) ? 32'h3 : 32'h2);
    end
    // Unmapped offset reads zero
    reg_access(8'h0c, 1'b0, 32'h0);
    check_idle();
    // Decode limit around every width boundary
    lookup(64'h0);
    lookup(64'hffff_ffff_ffff_ffff);
    for (int s = 46; s < 64; s++)
    begin
      lookup(64'h1 << s);
      lookup((64'h1 << s) - 64'h1);
    end
    check(32'(rdy_v), 32'h1f);
    tally_and_finish();
  end

  // Watchdog sized well above the roughly 150 cycles the tests take
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule

// >>> hdl/addr_width_limit.sv
// Checks a decode address against the reported maximum address width
`timescale 1ns/100ps
module addr_width_limit
  import capstat_pkg::*;
(
  // Width code as reported
  input wire logic [2:0] width_code,
  // Address to be decoded
  input wire logic [63:0] addr,
  // High when the address fits the width
  output logic in_range
);

  // Mask of address bits that lie above the reported width
  logic [63:0] high_mask;
  logic [6:0] bits;

  // Any set bit above the width puts the address out of range
  always_comb
  begin
    bits = aw_bits(width_code);
    high_mask = '1;
    for (int i = 0; i < 64; i++)
    begin
      if (i < int'(bits))
      begin
        high_mask[i] = 1'b0;
      end
    end
    in_range = ((addr & high_mask) == 64'h0);
  end

endmodule

// >>> hdl/capstat_pkg.sv
// Types and decode helpers shared by the capability register block
package capstat_pkg;

  // Register port request, one cycle per access
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Whole state of the top module
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic ok;
    logic err;
  } top_state_s;

  // Address width in bits for a width code; illegal codes give 64
  function automatic logic [6:0] aw_bits(input logic [2:0] code);
    logic [6:0] bits;
    bits = 7'h40;
    unique case (code)
      3'h0: bits = 7'h30;
      3'h1: bits = 7'h34;
      3'h2: bits = 7'h38;
      3'h3: bits = 7'h3c;
      default: bits = 7'h40;
    endcase
    return bits;
  endfunction

endpackage

// >>> hdl/capstat_regs.svh
// Offsets, field positions, reset values and timing for capability words
`ifndef CAPSTAT_REGS_SVH
`define CAPSTAT_REGS_SVH

// Register byte offsets
`define CAP_ONE_OFFSET 8'h04
`define CAP_TWO_OFFSET 8'h08

// Fields of common_capability_status_one
`define CAP1_MULTI_LSB 0
`define CAP1_MULTI_MSB 2

// Fields of common_capability_status_two
`define CAP2_READY_BIT 0
`define CAP2_PARTIAL_BIT 1
`define CAP2_GROUP_BIT 2
`define CAP2_LINE_BIT 3
`define CAP2_WIDTH_LSB 4
`define CAP2_WIDTH_MSB 6

// Highest legal address width code (64 bits)
`define AW_CODE_MAX 3'h4

// Reset values
`define RDATA_RST 32'h0000_0000

// Readiness time in ns and the clock period in ns
`define READY_TIME_NS 10000
`define REF_CLK_NS 10

`endif

// >>> hdl/common_capability_status_two.sv
// Read-only common capability words and address width decode limit
//
// Contract
// - Bit 1 reports partial cache line support
// - Bit 2 reports port grouping support
// - Grouping bit forced zero without multi-port
// - Grouping ports listed elsewhere, not here
// - Bit 3 reports 64B only or 128B
// - Bits 6:4 width code, reserved codes never
// - Bit 0 readiness, set within readiness time; set here READY_CYCLES + 1 cycles after reset, one past the budget
// - Multi-port bit set for two+ ports
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`include "capstat_regs.svh"
module common_capability_status_two
  import capstat_pkg::*;
#(
  // Partial cache line support, 0 or 1
  parameter bit PARTIAL_LINE = 1'b0,
  // Port grouping support before the multi-port gate
  parameter bit PORT_GROUPING = 1'b0,
  // 128B line support besides 64B
  parameter bit LINE_128 = 1'b0,
  // Maximum address width code, 0 to 4
  parameter logic [2:0] WIDTH_CODE = 3'h0,
  // Multi-port capability field of the first word
  parameter logic [2:0] MULTI_PORT = 3'h2,
  // Readiness budget in cycles, derived from ns and clock period
  parameter int READY_CYCLES = `READY_TIME_NS / `REF_CLK_NS
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  // Readiness level
  output logic discovery_ready,
  // Table entry decode check
  input wire logic lookup_valid,
  input wire logic [63:0] lookup_addr,
  output logic lookup_ok,
  output logic lookup_err
);

  // Elaboration checks: parameters the logic cannot serve
  generate
    if (WIDTH_CODE > `AW_CODE_MAX)
    begin : g_bad_width
      $error("width code above 64-bit encoding is reserved");
    end
    if (READY_CYCLES < 1)
    begin : g_bad_ready
      $error("readiness budget must be at least one cycle");
    end
  endgenerate

  // Registered state and its next value
  top_state_s st;
  top_state_s next_st;

  // Readiness from the timer
  logic timer_done;
  // Decode check result for the current lookup
  logic fits;
  // Effective fields as reported
  logic group_eff;
  logic [2:0] width_eff;
  // Fixed images of the two words, ready bit aside
  logic [31:0] word_one;
  logic [31:0] word_two;

  // Readiness timer; the bit starts clear after every reset
  ready_timer #(
    .CYCLES(READY_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .done(timer_done)
  );

  // Address range check against the reported width
  addr_width_limit u_limit (
    .width_code(width_eff),
    .addr(lookup_addr),
    .in_range(fits)
  );

  // Effective capability fields; constants once elaborated
  always_comb
  begin
    // Grouping only with multi-port; which ports can group is
    // described by a separate per-port vector, not this word
    group_eff = PORT_GROUPING & MULTI_PORT[0];
    // Clamp so a reserved code can never reach software
    if (WIDTH_CODE > `AW_CODE_MAX)
    begin
      width_eff = `AW_CODE_MAX;
    end
    else
    begin
      width_eff = WIDTH_CODE;
    end
  end

  // Build the two word images; unused bits read as zero
  always_comb
  begin
    word_one = '0;
    word_one[`CAP1_MULTI_MSB:`CAP1_MULTI_LSB] = MULTI_PORT;
    word_two = '0;
    word_two[`CAP2_READY_BIT] = st.ready;
    word_two[`CAP2_PARTIAL_BIT] = PARTIAL_LINE;
    word_two[`CAP2_GROUP_BIT] = group_eff;
    word_two[`CAP2_LINE_BIT] = LINE_128;
    word_two[`CAP2_WIDTH_MSB:`CAP2_WIDTH_LSB] = width_eff;
  end

  // Next state: read mux, readiness, decode check
  always_comb
  begin
    next_st = st;
    // Read data stands only in the cycle after the strobe
    next_st.rdata = '0;
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        `CAP_ONE_OFFSET: next_st.rdata = word_one;
        `CAP_TWO_OFFSET: next_st.rdata = word_two;
        // Unmapped offsets answer zero
        default: next_st.rdata = '0;
      endcase
    end
    // Writes have no path into any field; all read-only
    // (reg_req.wr and wdata are deliberately left unused)
    next_st.ready = timer_done;
    // One-cycle decode answer per lookup request
    next_st.ok = lookup_valid & fits;
    next_st.err = lookup_valid & ~fits;
  end

  // Register the whole state; synchronous reset
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st.rdata <= `RDATA_RST;
      st.ready <= 1'b0;
      st.ok <= 1'b0;
      st.err <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata = st.rdata;
  assign discovery_ready = st.ready;
  assign lookup_ok = st.ok;
  assign lookup_err = st.err;

  // Helper: cycles since reset, saturating past the budget
  localparam int SW = $clog2(READY_CYCLES + 2) + 1;
  logic [SW-1:0] since_rst;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      since_rst <= '0;
    end
    else if (since_rst <= SW'(READY_CYCLES))
    begin
      since_rst <= since_rst + SW'(1);
    end
  end

  // Helper: reported width in bits for the check below
  logic [6:0] rep_bits;
  assign rep_bits = aw_bits(width_eff);

  // Helper: read of each word this cycle
  logic rd_one;
  logic rd_two;
  assign rd_one = reg_req.rd && (reg_req.addr == `CAP_ONE_OFFSET);
  assign rd_two = reg_req.rd && (reg_req.addr == `CAP_TWO_OFFSET);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Partial line bit on the word read one cycle earlier
  AST_PARTIAL_BIT: assert property (
    rd_two |=> reg_rdata[`CAP2_PARTIAL_BIT] == PARTIAL_LINE)
    else $error("partial line bit wrong");

  // Grouping bit follows the gated capability
  AST_GROUP_BIT: assert property (
    rd_two |=> reg_rdata[`CAP2_GROUP_BIT] ==
      (PORT_GROUPING & MULTI_PORT[0]))
    else $error("grouping bit wrong");

  // Without multi-port the grouping bit reads zero
  AST_GROUP_FORCED: assert property (
    (rd_two && !MULTI_PORT[0]) |=> !reg_rdata[`CAP2_GROUP_BIT])
    else $error("grouping bit set on single port device");

  // Line size bit
  AST_LINE_BIT: assert property (
    rd_two |=> reg_rdata[`CAP2_LINE_BIT] == LINE_128)
    else $error("line size bit wrong");

  // Width code is never a reserved encoding
  AST_WIDTH_LEGAL: assert property (
    rd_two |=>
      reg_rdata[`CAP2_WIDTH_MSB:`CAP2_WIDTH_LSB] <= `AW_CODE_MAX)
    else $error("reserved width code reported");

  // An address with bits above the width is refused next cycle
  AST_RANGE_LIMIT: assert property (
    (lookup_valid && (lookup_addr >> rep_bits) != 64'h0)
      |=> lookup_err && !lookup_ok)
    else $error("address above reported width accepted");

  // A write, then a read: the upper bits stay zero and fixed
  AST_WRITE_IGNORED: assert property (
    reg_req.wr ##1 rd_two |=>
      reg_rdata[31:7] == 25'h0 &&
      reg_rdata[6:1] == $past(word_two[6:1]))
    else $error("write changed a read-only field");

  // Readiness is set once the budget has run out
  AST_READY_BOUND: assert property (
    (since_rst > SW'(READY_CYCLES)) |-> discovery_ready)
    else $error("readiness not set within budget");

  // Ready, once set, holds until reset
  AST_READY_HOLDS: assert property (
    discovery_ready |=> discovery_ready [*2])
    else $error("readiness dropped");

  // Multi-port bit in the first word
  AST_MULTI_BIT: assert property (
    rd_one |=> reg_rdata[`CAP1_MULTI_LSB] == MULTI_PORT[0])
    else $error("multi-port bit wrong");

  // No read strobe, no read data
  AST_IDLE_ZERO: assert property (
    !reg_req.rd |=> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");

  // Width field carries exactly the configured legal code
  AST_WIDTH_FIELD: assert property (
    rd_two |=>
      reg_rdata[`CAP2_WIDTH_MSB:`CAP2_WIDTH_LSB] == WIDTH_CODE)
    else $error("width code differs from configuration");

  // Readiness bit of a read shows the level at the strobe
  AST_READY_BIT_READ: assert property (
    rd_two |=> reg_rdata[`CAP2_READY_BIT] == $past(discovery_ready))
    else $error("readiness bit on read differs from level");

  // Readiness stays clear while the budget is still running
  AST_READY_NOT_EARLY: assert property (
    (since_rst <= SW'(READY_CYCLES)) |-> !discovery_ready)
    else $error("readiness set before its timer ran out");

  // First word shows nothing beyond the multi-port field
  AST_ONE_SPARE_ZERO: assert property (
    rd_one |=> reg_rdata[31:3] == 29'h0)
    else $error("spare bits of first word not zero");

  // An unmapped offset answers zero
  AST_UNMAPPED_ZERO: assert property (
    (reg_req.rd && !rd_one && !rd_two) |=> reg_rdata == 32'h0)
    else $error("unmapped offset returned data");

  // An address that fits the width is accepted next cycle
  AST_RANGE_ACCEPT: assert property (
    (lookup_valid && (lookup_addr >> rep_bits) == 64'h0)
      |=> lookup_ok && !lookup_err)
    else $error("address within reported width refused");

  // No lookup request, no answer
  AST_LOOKUP_IDLE: assert property (
    !lookup_valid |=> !lookup_ok && !lookup_err)
    else $error("lookup answer without request");

  // Main scenarios
  COV_READ_TWO_READY: cover property (
    discovery_ready && rd_two ##1 reg_rdata[`CAP2_READY_BIT]);
  COV_READ_BEFORE_READY: cover property (
    !discovery_ready && rd_two);
  COV_LOOKUP_ERR: cover property (lookup_err);
  COV_WRITE_THEN_READ: cover property (reg_req.wr ##1 rd_one);
  COV_LOOKUP_OK: cover property (lookup_ok);

endmodule

// >>> hdl/ready_timer.sv
// Counts ref_clk cycles after reset and flags discovery readiness
`timescale 1ns/100ps
module ready_timer
  import capstat_pkg::*;
#(
  parameter int CYCLES = 1000
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Readiness level
  output logic done
);

  localparam int CW = $clog2(CYCLES + 1);

  // Timer state: count and done flag
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic done;
  } timer_state_s;

  timer_state_s st;
  timer_state_s next_st;

  // Refuse a zero budget: the bit could never start clear
  generate
    if (CYCLES < 1)
    begin : g_bad
      $error("ready_timer: CYCLES must be at least 1");
    end
  endgenerate

  // Count up once, then hold done high until the next reset
  always_comb
  begin
    next_st = st;
    if (!st.done)
    begin
      next_st.cnt = st.cnt + CW'(1);
      // Set no later than the budget allows
      if (st.cnt == CW'(CYCLES - 1))
      begin
        next_st.done = 1'b1;
      end
    end
  end

  // Register the state; synchronous reset
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign done = st.done;

endmodule
